//--- hw/plrc_pkg.sv
// Package for the power loss restore controller.
// Holds restore mode encodings, timing constants and state types.
package plrc_pkg;

   // Restore mode encodings
   localparam logic [1:0] MODE_REMAIN_OFF = 2'h0;
   localparam logic [1:0] MODE_TURN_ON    = 2'h1;
   localparam logic [1:0] MODE_LAST_STATE = 2'h2;

   // Clock rate and stability window
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned WINDOW_SEC   = 30;
   localparam int unsigned WINDOW_CYC   = WINDOW_SEC * CLK_HZ;
   // Standby presence must persist this long to count as returned
   localparam int unsigned SB_FILT_US   = 10;
   localparam int unsigned SB_FILT_CYC  = SB_FILT_US * (CLK_HZ / 1_000_000);

   // Reset values
   localparam logic RST_LAST_ON = 1'b0;

   // Top level sequencing states
   typedef enum logic [2:0] {
      PLRC_ST_WAIT_SB,
      PLRC_ST_DECIDE,
      PLRC_ST_RUN,
      PLRC_ST_WATCH,
      PLRC_ST_OFF
   } plrc_state_t;

endpackage : plrc_pkg

//--- hw/plrc_top.sv
// Power loss restore controller: watches the standby rail and decides
// whether to switch the main supply on when standby power returns.
// Assumes the controller is powered from standby; nrst is its own
// power-on reset, and all pin inputs are asynchronous to sys_clk.
//
// Summary of operation
// RQ1 - Monitor standby rail continuously after shutdown or loss
// RQ2 - Stable standby through window means proper switch-off
// RQ3 - Standby lost within window means AC loss
// RQ4 - Turn-on mode powers system after standby returns
// RQ5 - Remain-off mode keeps system off after return
// RQ6 - Last-state mode restores recorded on/off state
// RQ7 - Window timer used only in last-state mode
// RQ8 - Loss soon after shutdown may restore on
// RQ9 - Without standby rail, mode has no effect
// RQ10 - Drive active-low main supply enable when on
// RQ11 - Carrier holds power good low until stable
// RQ12 - Two-bit mode; last state kept on standby
`timescale 1ns/100ps
`default_nettype none
module plrc_top
   import plrc_pkg::*;
#(
   parameter int unsigned WIN_CYC  = WINDOW_CYC,
   parameter int unsigned FILT_CYC = SB_FILT_CYC
)(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // Supply side pins
   input  wire logic       standby_present,
   input  wire logic       standby_capable,
   input  wire logic       carrier_power_good,
   // Platform requests (pins)
   input  wire logic       on_request,
   input  wire logic       off_request,
   // Configuration
   input  wire logic [1:0] restore_mode,
   // Outputs
   output logic            main_supply_enable_n,
   output logic            system_on,
   output logic            last_state_on,
   output logic            ac_loss_seen,
   output logic            module_reset_n
);
   localparam int FW = $clog2(FILT_CYC + 1);

   // Two-stage synchronisers for every pin input
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic       sb_s, cap_s, pg_s, on_s, off_s;
   logic [1:0] mode_s; // Mode is quasi-static; sampled with the pins

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= {standby_present, standby_capable, carrier_power_good,
                   on_request, off_request, 1'b0};
         sync2 <= sync1;
      end
   end
   assign {sb_s, cap_s, pg_s, on_s, off_s} = sync2[5:1];

   logic [1:0] mode_m1;
   logic [1:0] mode_m2;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_m1 <= MODE_REMAIN_OFF;
         mode_m2 <= MODE_REMAIN_OFF;
      end
      else
      begin
         mode_m1 <= restore_mode;
         mode_m2 <= mode_m1;
      end
   end
   assign mode_s = mode_m2;

   // Window timer
   plrc_win_if win ();
   plrc_window_timer #(.WIN_CYC(WIN_CYC)) u_win (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .win     (win)
   );

   // Sequencer state
   plrc_state_t  state;         // Current phase
   logic [FW-1:0] filt;         // Standby return qualification count
   logic         last_on;       // Recorded last state
   logic         ac_loss;       // Last event classified as AC loss
   logic         sys_on;        // Main supply requested on
   logic         win_start;
   plrc_state_t  next_state;
   logic [FW-1:0] next_filt;
   logic         next_last_on;
   logic         next_ac_loss;
   logic         next_sys_on;
   logic         next_win_start;

   // Sequencing decisions
   always_comb
   begin
      next_state     = state;
      next_filt      = filt;
      next_last_on   = last_on;
      next_ac_loss   = ac_loss;
      next_sys_on    = sys_on;
      next_win_start = 1'b0;
      case (state)
         // Wait for standby rail to stand steady
         PLRC_ST_WAIT_SB:
         begin
            next_sys_on = 1'b0;
            if (!sb_s)
               next_filt = '0;
            else if (filt == FW'(FILT_CYC))
               next_state = PLRC_ST_DECIDE;
            else
               next_filt = filt + FW'(1);
         end
         // Standby returned: apply the restore mode
         PLRC_ST_DECIDE:
         begin
            next_filt = '0;
            if (!cap_s) // RQ9
               next_state = PLRC_ST_OFF;
            else if (mode_s == MODE_TURN_ON) // RQ4
               next_state = PLRC_ST_RUN;
            else if (mode_s == MODE_LAST_STATE && last_on) // RQ6
               next_state = PLRC_ST_RUN;
            else // RQ5
               next_state = PLRC_ST_OFF;
            next_sys_on = (next_state == PLRC_ST_RUN);
         end
         // System running; a standby drop is a loss while on
         PLRC_ST_RUN:
         begin
            next_last_on = 1'b1; // RQ12
            if (!sb_s)
            begin
               next_ac_loss = 1'b1;
               next_sys_on  = 1'b0;
               next_state   = PLRC_ST_WAIT_SB;
            end
            else if (off_s)
            begin
               // Shutdown: only last-state mode waits out the window
               next_sys_on  = 1'b0;
               next_ac_loss = 1'b0;
               if (mode_s == MODE_LAST_STATE) // RQ7
               begin
                  // Last state stays on until the window proves it
                  next_state     = PLRC_ST_WATCH;
                  next_win_start = 1'b1;
               end
               else
               begin
                  // No window: a later standby drop is no AC loss
                  next_last_on = 1'b0;
                  next_state   = PLRC_ST_OFF;
               end
            end
         end
         // Last-state mode only: standby watched through the window
         PLRC_ST_WATCH:
         begin
            if (!sb_s) // RQ1 RQ3 RQ8
            begin
               next_ac_loss = 1'b1;
               next_state   = PLRC_ST_WAIT_SB;
            end
            else if (win.expired) // RQ2
            begin
               next_last_on = 1'b0;
               next_state   = PLRC_ST_OFF;
            end
            else if (on_s)
            begin
               next_sys_on = 1'b1;
               next_state  = PLRC_ST_RUN;
            end
         end
         // Off with standby present
         PLRC_ST_OFF:
         begin
            if (!sb_s) // RQ1
               next_state = PLRC_ST_WAIT_SB;
            else if (on_s)
            begin
               next_sys_on = 1'b1;
               next_state  = PLRC_ST_RUN;
            end
         end
         default:
            next_state = PLRC_ST_WAIT_SB;
      endcase
   end

   // Timer abort whenever the watch phase is left
   assign win.start = win_start;
   assign win.abort = (state != PLRC_ST_WATCH) && !win_start; // RQ7

   // Sequencer registers; last_on lives on standby power
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state     <= PLRC_ST_WAIT_SB;
         filt      <= '0;
         last_on   <= RST_LAST_ON;
         ac_loss   <= 1'b0;
         sys_on    <= 1'b0;
         win_start <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         filt      <= next_filt;
         last_on   <= next_last_on;
         ac_loss   <= next_ac_loss;
         sys_on    <= next_sys_on;
         win_start <= next_win_start;
      end
   end

   // Registered outputs
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         main_supply_enable_n <= 1'b1;
         system_on            <= 1'b0;
         last_state_on        <= RST_LAST_ON;
         ac_loss_seen         <= 1'b0;
         module_reset_n       <= 1'b0;
      end
      else
      begin
         main_supply_enable_n <= !sys_on; // RQ10
         system_on            <= sys_on;
         last_state_on        <= last_on;
         ac_loss_seen         <= ac_loss;
         module_reset_n       <= sys_on && pg_s; // RQ11
      end
   end

endmodule // plrc_top
`default_nettype wire

//--- hw/plrc_win_if.sv
// Interface between the sequencer and its stability window timer.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface plrc_win_if;
   logic start;   // Pulse: (re)start the window
   logic abort;   // Level: stop the window
   logic expired; // Pulse: window completed
   modport ctrl (output start, output abort, input expired);
   modport tmr  (input start, input abort, output expired);
endinterface : plrc_win_if
`default_nettype wire

//--- hw/plrc_window_timer.sv
// Stability window timer for the power loss restore controller.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module plrc_window_timer
   import plrc_pkg::*;
#(
   parameter int unsigned WIN_CYC = WINDOW_CYC
)(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic nrst,
   // Control
   plrc_win_if.tmr   win
);
   localparam int W = $clog2(WIN_CYC + 1);

   logic [W-1:0] cnt;        // Remaining cycles
   logic         run;        // Window active
   logic         expired;    // Completion pulse
   logic [W-1:0] next_cnt;
   logic         next_run;
   logic         next_expired;

   // Countdown; abort beats start so a vanished rail always stops it
   always_comb
   begin
      next_cnt     = cnt;
      next_run     = run;
      next_expired = 1'b0;
      if (win.abort)
      begin
         next_run = 1'b0;
      end
      else if (win.start)
      begin
         next_cnt = W'(WIN_CYC - 1);
         next_run = 1'b1;
      end
      else if (run)
      begin
         if (cnt == '0)
         begin
            next_run     = 1'b0;
            next_expired = 1'b1;
         end
         else
         begin
            next_cnt = cnt - W'(1);
         end
      end
   end

   // State registers
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt     <= '0;
         run     <= 1'b0;
         expired <= 1'b0;
      end
      else
      begin
         cnt     <= next_cnt;
         run     <= next_run;
         expired <= next_expired;
      end
   end

   assign win.expired = expired;

endmodule // plrc_window_timer
`default_nettype wire

//--- verif/plrc_psu_model.sv
// Supply model with a standby rail for the restore controller.
// Assumes the bench switches AC input with ac_on off the clock edge.
`timescale 1ns/100ps
`default_nettype none
module plrc_psu_model
#(
   parameter int PG_DLY = 4
)(
   // Clock and AC input
   input  wire logic sys_clk,
   input  wire logic ac_on,
   // Controller side
   input  wire logic main_supply_enable_n,
   output var logic  standby_present,
   output var logic  carrier_power_good
);
   int cnt = 0; // Cycles since main rails came up

   // Standby follows AC directly
   assign standby_present = ac_on;

   // Settling count restarts whenever main rails drop
   always @(posedge sys_clk)
   begin
      if (!ac_on || main_supply_enable_n)
         cnt <= 0;
      else if (cnt < PG_DLY)
         cnt <= cnt + 1;
   end

   // Good held low until the rails settle
   assign carrier_power_good = (cnt == PG_DLY);
endmodule // plrc_psu_model
`default_nettype wire

//--- verif/plrc_top_asserts.sv
// Checker for the restore controller, bound onto plrc_top.
// Sees only top ports; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module plrc_top_asserts
   import plrc_pkg::*;
#(
   parameter int unsigned WIN_CYC  = WINDOW_CYC,
   parameter int unsigned FILT_CYC = SB_FILT_CYC
)(
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       nrst,
   // Inputs
   input wire logic       standby_present,
   input wire logic       standby_capable,
   input wire logic       carrier_power_good,
   input wire logic       on_request,
   input wire logic       off_request,
   input wire logic [1:0] restore_mode,
   // Outputs
   input wire logic       main_supply_enable_n,
   input wire logic       system_on,
   input wire logic       last_state_on,
   input wire logic       ac_loss_seen,
   input wire logic       module_reset_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   int off_cnt; // Cycles off with standby up

   // Counts the stable-standby time since switch-off
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         off_cnt <= 0;
      else if (system_on || !standby_present)
         off_cnt <= 0;
      else
         off_cnt <= off_cnt + 1;
   end

   sequence sb_gone;
      !standby_present [*6];
   endsequence
   // Power-up with no operator request behind it
   sequence quiet_rise;
      !on_request [*6] ##1 $rose(system_on);
   endsequence

   en_on_a: assert property (system_on |-> !main_supply_enable_n)
      else $error("enable not low while on");
   en_off_a: assert property (!system_on |-> main_supply_enable_n)
      else $error("enable not high while off");
   pg_hold_a: assert property (!carrier_power_good [*4] |-> !module_reset_n)
      else $error("reset released without power good");
   off_rst_a: assert property (!system_on [*2] |-> !module_reset_n)
      else $error("reset released while off");
   sb_loss_a: assert property (sb_gone |-> !system_on)
      else $error("on without standby");
   quiet_mode_a: assert property (quiet_rise |-> restore_mode != MODE_REMAIN_OFF)
      else $error("restored on in remain off");
   no_rail_a: assert property (quiet_rise |-> standby_capable)
      else $error("restored on without standby rail");
   loss_keep_a: assert property (ac_loss_seen |-> last_state_on)
      else $error("last state lost after loss");
   last_clr_a: assert property ($fell(last_state_on) |-> !system_on)
      else $error("last state cleared while on");
   window_a: assert property ($fell(last_state_on) &&
      restore_mode == MODE_LAST_STATE |-> off_cnt + 2 >= WIN_CYC &&
      off_cnt <= WIN_CYC + 6)
      else $error("window length wrong");
endmodule // plrc_top_asserts

bind plrc_top plrc_top_asserts #(.WIN_CYC(WIN_CYC), .FILT_CYC(FILT_CYC))
   i_plrc_top_asserts (.sys_clk(sys_clk), .nrst(nrst),
   .standby_present(standby_present), .standby_capable(standby_capable),
   .carrier_power_good(carrier_power_good), .on_request(on_request),
   .off_request(off_request), .restore_mode(restore_mode),
   .main_supply_enable_n(main_supply_enable_n), .system_on(system_on),
   .last_state_on(last_state_on), .ac_loss_seen(ac_loss_seen),
   .module_reset_n(module_reset_n));
`default_nettype wire

//--- verif/tb_plrc_top.sv
// Testbench for the restore controller with a supply model.
// Assumes short window and filter counts set here.
`timescale 1ns/100ps
`default_nettype none
module tb_plrc_top
   import plrc_pkg::*;
   ;
   localparam int unsigned WIN  = 50;
   localparam int unsigned FILT = 3;
   logic sys_clk = 0, nrst = 0, ac_on = 0, standby_capable = 1;
   logic on_request = 0, off_request = 0;
   logic [1:0] restore_mode = MODE_TURN_ON;
   logic standby_present, carrier_power_good, main_supply_enable_n;
   logic system_on, last_state_on, ac_loss_seen, module_reset_n;
   int mismatches = 0, checked = 0, cycles = 0;

   plrc_top #(.WIN_CYC(WIN), .FILT_CYC(FILT)) i_plrc_top (
      .sys_clk(sys_clk), .nrst(nrst), .standby_present(standby_present),
      .standby_capable(standby_capable),
      .carrier_power_good(carrier_power_good), .on_request(on_request),
      .off_request(off_request), .restore_mode(restore_mode),
      .main_supply_enable_n(main_supply_enable_n), .system_on(system_on),
      .last_state_on(last_state_on), .ac_loss_seen(ac_loss_seen),
      .module_reset_n(module_reset_n));
   plrc_psu_model i_plrc_psu_model (.sys_clk(sys_clk), .ac_on(ac_on),
      .main_supply_enable_n(main_supply_enable_n),
      .standby_present(standby_present),
      .carrier_power_good(carrier_power_good));

   always #50 sys_clk = ~sys_clk;

   // Cuts a hang short well past the expected run length
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Inputs always move 10 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask

   task automatic chk(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_on(input logic exp, input int n);
      for (int i = 0; i < n && system_on !== exp; i++)
         tick(1);
      chk(system_on, exp);
   endtask

   // AC switched, then time for sync, filter and decision
   task automatic ac(input logic v);
      ac_on = v;
      tick(20);
   endtask

   task automatic press(input logic on);
      on_request = on;
      off_request = !on;
      wait_on(on, 20);
      on_request = 0;
      off_request = 0;
      // Let an edge pass so a following press never re-drives in one step
      tick(1);
   endtask

   task automatic t_turn_on;
      ac(1);
      wait_on(1, 40);
      tick(12);
      chk(main_supply_enable_n, 0);
      chk(module_reset_n, 1);
      ac(0);
      chk(system_on, 0);
      chk(ac_loss_seen, 1);
      chk(last_state_on, 1);
      ac(1);
      wait_on(1, 40);
   endtask

   task automatic t_remain_off;
      ac(0);
      restore_mode = MODE_REMAIN_OFF;
      ac(1);
      tick(20);
      chk(system_on, 0);
      chk(main_supply_enable_n, 1);
      press(1);
      press(0);
      tick(2);
      chk(last_state_on, 0);
      chk(ac_loss_seen, 0);
   endtask

   task automatic t_last_state;
      restore_mode = MODE_LAST_STATE;
      press(1);
      press(0);
      tick(5);
      chk(last_state_on, 1);
      // Loss inside the window
      ac(0);
      chk(ac_loss_seen, 1);
      chk(last_state_on, 1);
      ac(1);
      wait_on(1, 40);
      press(0);
      tick(WIN + 10);
      chk(last_state_on, 0);
      ac(0);
      chk(ac_loss_seen, 0);
      ac(1);
      chk(system_on, 0);
   endtask

   task automatic t_no_rail;
      ac(0);
      standby_capable = 0;
      restore_mode = MODE_TURN_ON;
      ac(1);
      tick(20);
      chk(system_on, 0);
      standby_capable = 1;
   endtask

   // Spare mode code 3 behaves as remain off and uses no window
   task automatic t_spare_mode;
      restore_mode = 2'h3;
      press(1);
      ac(0);
      ac(1);
      chk(system_on, 0);
      chk(last_state_on, 1);
      press(1);
      press(0);
      tick(2);
      chk(last_state_on, 0);
      chk(ac_loss_seen, 0);
   endtask

   initial
   begin
      tick(4);
      nrst = 1;
      t_turn_on();
      t_remain_off();
      t_last_state();
      t_no_rail();
      t_spare_mode();
      tally_and_finish();
   end
endmodule // tb_plrc_top
`default_nettype wire
